// ### include/cascade_timer_defs.svh
// register map, field positions, reset values and prescaler taps of the cascaded interval timer
`ifndef CASCADE_TIMER_DEFS_SVH
`define CASCADE_TIMER_DEFS_SVH

// register addresses on the plain register port
`define ADDR_W 12
`define ADDR_LOW_MODE 12'hfa0
`define ADDR_OUT_ENABLE 12'hfa2
`define ADDR_HIGH_MODE 12'hfa8
`define ADDR_LOW_MATCH 12'hfb0
`define ADDR_HIGH_MATCH 12'hfb4
`define ADDR_LOW_COUNT 12'hfb8
`define ADDR_HIGH_COUNT 12'hfbc
`define ADDR_STATUS 12'hfc0

// mode register fields
`define MODE_SEL_HI 6
`define MODE_SEL_LO 4
`define MODE_START_BIT 3
`define MODE_RUN_BIT 2
`define MODE_OP_HI 1
`define MODE_OP_LO 0
`define MODE_OP_CASCADE 2'h2
`define MODE_RESET 8'h00
`define HIGH_MODE_CASCADE 8'h22

// output enable nibble and status fields
`define OUT_ENABLE_BIT 3
`define STATUS_IRQ_BIT 0
`define STATUS_TOGGLE_BIT 1

// prescaler tap exponents of the main oscillator clock
`define TAP_EXP_FAST 2
`define TAP_EXP_4 4
`define TAP_EXP_6 6
`define TAP_EXP_8 8
`define TAP_EXP_SLOW 10

`endif

// ### include/cascade_timer_pkg.sv
// types shared by the cascaded interval timer
package cascade_timer_pkg;

    // count pulse selection codes of the low and high channels
    typedef enum logic [2:0] {
        SEL_EVENT_RISE = 3'h0,
        SEL_EVENT_FALL = 3'h1,
        SEL_LOW_OVERFLOW = 3'h2,
        SEL_DIV_4 = 3'h3,
        SEL_DIV_1024 = 3'h4,
        SEL_DIV_256 = 3'h5,
        SEL_DIV_64 = 3'h6,
        SEL_DIV_16 = 3'h7
    } pulse_sel_t;

    // one-cycle ticks from the prescaler, index order fast to slow
    typedef logic [4:0] tap_ticks_t;

endpackage

// ### src/osc_prescaler.sv
// free-running prescaler giving one-cycle ticks at the main oscillator taps
`timescale 1ns/1ps
`include "cascade_timer_defs.svh"

module osc_prescaler #(
    parameter int DIV_W = `TAP_EXP_SLOW
) (
    input wire logic clock_i,
    input wire logic rst_i,
    output cascade_timer_pkg::tap_ticks_t ticks_o
);

    logic [DIV_W-1:0] div_r;

    // the slowest tap needs every bit of the divider
    if (DIV_W < `TAP_EXP_SLOW) begin : g_check
        $error("osc_prescaler: DIV_W too small for the slowest tap");
    end

    // true when the low k bits of the divider are all ones
    function automatic logic tap_hit(input logic [DIV_W-1:0] cnt, input int k);
        logic hit;
        hit = 1'b1;
        for (int i = 0; i < k; i++) begin
            hit = hit & cnt[i];
        end
        return hit;
    endfunction

    // divider runs from reset onward, never gated
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + 1'b1;
        end
    end

    // registered ticks, one cycle wide each
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            ticks_o <= '0;
        end else begin
            ticks_o[0] <= tap_hit(div_r, `TAP_EXP_FAST);
            ticks_o[1] <= tap_hit(div_r, `TAP_EXP_4);
            ticks_o[2] <= tap_hit(div_r, `TAP_EXP_6);
            ticks_o[3] <= tap_hit(div_r, `TAP_EXP_8);
            ticks_o[4] <= tap_hit(div_r, `TAP_EXP_SLOW);
        end
    end

endmodule // osc_prescaler

// ### src/cascaded_timer.sv
// cascaded 16-bit interval timer and event counter with register port and toggle output
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`include "cascade_timer_defs.svh"

module cascaded_timer #(
    parameter int DATA_W = 8
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic [`ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic write_i,
    input wire logic read_i,
    input wire logic low_event_input_i,
    output logic [DATA_W-1:0] rdata_o,
    output logic timer_irq_flag_o,
    output logic timer_output_pin_o
);

    // the counters and registers are byte wide by construction
    if (DATA_W != 8) begin : g_check
        $error("cascaded_timer: DATA_W must be 8");
    end

    logic [7:0] low_mode_r;
    logic [7:0] high_mode_r;
    logic [7:0] low_match_register_r;
    logic [7:0] high_match_register_r;
    logic [7:0] low_count_register_r;
    logic [7:0] high_count_register_r;
    logic timer_output_enable_r;
    logic toggle_output_flop_r;
    logic timer_irq_flag_r;
    logic evt_sync1_r;
    logic evt_sync2_r;
    logic evt_sync3_r;
    logic evt_level_r;
    cascade_timer_pkg::tap_ticks_t ticks;
    cascade_timer_pkg::pulse_sel_t low_pulse_select_bits;
    cascade_timer_pkg::pulse_sel_t high_pulse_select_bits;
    logic wr_low_mode;
    logic wr_out_enable;
    logic wr_high_mode;
    logic wr_status;
    logic start_req;
    logic count_run_bit;
    logic evt_rise;
    logic evt_fall;
    logic count_pulse;
    logic low_hit;
    logic high_hit;
    logic full_event;
    logic low_overflow;
    logic high_pulse;
    logic [7:0] rdata_nxt;

    // write decode, shared between register and counter processes
    function automatic logic hit_wr(input logic [`ADDR_W-1:0] a, input logic [`ADDR_W-1:0] target);
        return a == target;
    endfunction

    assign wr_low_mode = write_i && hit_wr(addr_i, `ADDR_LOW_MODE);
    assign wr_out_enable = write_i && hit_wr(addr_i, `ADDR_OUT_ENABLE);
    assign wr_high_mode = write_i && hit_wr(addr_i, `ADDR_HIGH_MODE);
    assign wr_status = write_i && hit_wr(addr_i, `ADDR_STATUS);
    assign start_req = wr_low_mode && wdata_i[`MODE_START_BIT];
    assign count_run_bit = low_mode_r[`MODE_RUN_BIT];

    osc_prescaler #(
        .DIV_W(`TAP_EXP_SLOW)
    ) u_prescaler (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .ticks_o(ticks)
    );

    // event pin synchroniser; only the second and third stages are looked at
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            evt_sync1_r <= 1'b0;
            evt_sync2_r <= 1'b0;
            evt_sync3_r <= 1'b0;
            evt_level_r <= 1'b0;
        end else begin
            evt_sync1_r <= low_event_input_i;
            evt_sync2_r <= evt_sync1_r;
            evt_sync3_r <= evt_sync2_r;
            if (evt_sync2_r == evt_sync3_r) begin
                evt_level_r <= evt_sync3_r;
            end
        end
    end

    // a level change is accepted once two stages agree
    assign evt_rise = (evt_sync2_r == evt_sync3_r) && evt_sync3_r && !evt_level_r;
    assign evt_fall = (evt_sync2_r == evt_sync3_r) && !evt_sync3_r && evt_level_r;

    // count pulse selection; the prohibited code gives no pulse
    assign low_pulse_select_bits = cascade_timer_pkg::pulse_sel_t'(low_mode_r[`MODE_SEL_HI:`MODE_SEL_LO]);
    assign high_pulse_select_bits = cascade_timer_pkg::pulse_sel_t'(high_mode_r[`MODE_SEL_HI:`MODE_SEL_LO]);
    always_comb begin
        count_pulse = 1'b0;
        case (low_pulse_select_bits)
            cascade_timer_pkg::SEL_EVENT_RISE: count_pulse = evt_rise;
            cascade_timer_pkg::SEL_EVENT_FALL: count_pulse = evt_fall;
            cascade_timer_pkg::SEL_DIV_4: count_pulse = ticks[0];
            cascade_timer_pkg::SEL_DIV_1024: count_pulse = ticks[4];
            cascade_timer_pkg::SEL_DIV_256: count_pulse = ticks[3];
            cascade_timer_pkg::SEL_DIV_64: count_pulse = ticks[2];
            cascade_timer_pkg::SEL_DIV_16: count_pulse = ticks[1];
            default: count_pulse = 1'b0;
        endcase
    end

    // comparators run every cycle, independent of the pulse
    assign low_hit = low_count_register_r == low_match_register_r;
    assign high_hit = high_count_register_r == high_match_register_r;
    assign full_event = count_run_bit && count_pulse && low_hit && high_hit;
    assign low_overflow = count_run_bit && count_pulse && (low_count_register_r == 8'hff) && !full_event;
    // resolution comes from the low channel alone; high only sees low overflow
    assign high_pulse = low_overflow && (high_pulse_select_bits == cascade_timer_pkg::SEL_LOW_OVERFLOW);

    // mode registers; the low mode start bit is never stored, so it reads back as zero
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            low_mode_r <= `MODE_RESET;
            high_mode_r <= `MODE_RESET;
        end else begin
            if (wr_low_mode) begin
                low_mode_r <= wdata_i & ~(8'h01 << `MODE_START_BIT);
            end
            if (wr_high_mode) begin
                high_mode_r <= wdata_i;
            end
        end
    end

    // modulo registers; a new value smaller than the count waits for a wrap
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            low_match_register_r <= 8'hff;
            high_match_register_r <= 8'hff;
        end else begin
            if (write_i && hit_wr(addr_i, `ADDR_LOW_MATCH)) begin
                low_match_register_r <= wdata_i;
            end
            if (write_i && hit_wr(addr_i, `ADDR_HIGH_MATCH)) begin
                high_match_register_r <= wdata_i;
            end
        end
    end

    // write-only output enable nibble, only bit 3 is implemented
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            timer_output_enable_r <= 1'b0;
        end else if (wr_out_enable) begin
            timer_output_enable_r <= wdata_i[`OUT_ENABLE_BIT];
        end
    end

    // cascaded count; start clear wins over counting in the same cycle
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            low_count_register_r <= 8'h00;
            high_count_register_r <= 8'h00;
        end else if (start_req) begin
            low_count_register_r <= 8'h00;
            high_count_register_r <= 8'h00;
        end else if (full_event) begin
            low_count_register_r <= 8'h00;
            high_count_register_r <= 8'h00;
        end else if (count_run_bit && count_pulse) begin
            low_count_register_r <= low_count_register_r + 8'h01;
            if (high_pulse) begin
                high_count_register_r <= high_count_register_r + 8'h01;
            end
        end
    end

    // interrupt flag; a match in the clearing cycle keeps the flag set
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            timer_irq_flag_r <= 1'b0;
        end else if (full_event) begin
            timer_irq_flag_r <= 1'b1;
        end else if (start_req || (wr_status && wdata_i[`STATUS_IRQ_BIT])) begin
            timer_irq_flag_r <= 1'b0;
        end
    end

    // toggle flop flips on every full match
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            toggle_output_flop_r <= 1'b0;
        end else if (full_event) begin
            toggle_output_flop_r <= !toggle_output_flop_r;
        end
    end

    // pin driven from a flop so it carries no decode glitches
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            timer_output_pin_o <= 1'b0;
            timer_irq_flag_o <= 1'b0;
        end else begin
            timer_output_pin_o <= timer_output_enable_r && toggle_output_flop_r;
            timer_irq_flag_o <= timer_irq_flag_r;
        end
    end

    // read mux; unmapped and write-only addresses read as zero
    always_comb begin
        rdata_nxt = 8'h00;
        case (addr_i)
            `ADDR_LOW_MODE: rdata_nxt = low_mode_r;
            `ADDR_HIGH_MODE: rdata_nxt = high_mode_r;
            `ADDR_LOW_MATCH: rdata_nxt = low_match_register_r;
            `ADDR_HIGH_MATCH: rdata_nxt = high_match_register_r;
            `ADDR_LOW_COUNT: rdata_nxt = low_count_register_r;
            `ADDR_HIGH_COUNT: rdata_nxt = high_count_register_r;
            `ADDR_STATUS: rdata_nxt = {6'h00, toggle_output_flop_r, timer_irq_flag_r};
            default: rdata_nxt = 8'h00;
        endcase
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            rdata_o <= '0;
        end else if (read_i) begin
            rdata_o <= rdata_nxt;
        end else begin
            rdata_o <= '0;
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    AST_PIN_LOW_DISABLED: assert property (!timer_output_enable_r |=> !timer_output_pin_o)
        else $error("pin not low while output disabled");
    AST_PIN_FOLLOWS_FLOP: assert property (timer_output_enable_r |=>
        timer_output_pin_o == $past(toggle_output_flop_r))
        else $error("pin does not follow toggle flop");
    AST_MATCH_SETS_FLAG: assert property (full_event |=> timer_irq_flag_r ##1 timer_irq_flag_o)
        else $error("full match did not raise flag");
    AST_MATCH_TOGGLES: assert property (full_event |=> toggle_output_flop_r != $past(toggle_output_flop_r))
        else $error("full match did not flip toggle flop");
    AST_MATCH_RESTARTS: assert property (full_event |=>
        low_count_register_r == 8'h00 && high_count_register_r == 8'h00)
        else $error("counts not cleared after full match");
    AST_NO_FLAG_WITHOUT_MATCH: assert property (!full_event && !timer_irq_flag_r |=> !timer_irq_flag_r)
        else $error("flag set without a full match");
    AST_HOLD_STOPPED: assert property (!count_run_bit && !start_req |=>
        $stable(low_count_register_r) && $stable(high_count_register_r))
        else $error("count moved while stopped");
    AST_START_CLEARS: assert property (start_req && !full_event |=>
        low_count_register_r == 8'h00 && !timer_irq_flag_r)
        else $error("start did not clear count and flag");
    AST_START_SELF_CLEARS: assert property (start_req |=> !low_mode_r[`MODE_START_BIT])
        else $error("start bit did not clear itself");
    AST_CASCADE_CARRY: assert property (high_pulse && !start_req |=>
        high_count_register_r == $past(high_count_register_r) + 8'h01 && low_count_register_r == 8'h00)
        else $error("low overflow did not carry into high count");
    AST_RESET_MODES: assert property (@(posedge clock_i) disable iff (1'b0) rst_i |=>
        low_mode_r == `MODE_RESET && high_mode_r == `MODE_RESET)
        else $error("reset left a mode register set");

    COV_INTERVAL: cover property (full_event ##[1:300] full_event);
    COV_CARRY: cover property (high_pulse);
    COV_START_ON_MATCH: cover property (start_req && full_event);
    COV_PIN_HIGH: cover property (timer_output_pin_o);

endmodule // cascaded_timer

// ### dv/cascaded_16bit_interval_timer_tb.sv
// self-checking testbench for the cascaded 16-bit interval timer
`timescale 1ns/1ps
`include "cascade_timer_defs.svh"

module cascaded_16bit_interval_timer_tb;

    logic clock_i;
    logic rst_i;
    logic [`ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic write_s;
    logic read_s;
    logic event_s;
    logic [7:0] rdata;
    logic irq;
    logic pin;
    logic rd_pend = 1'b0;
    logic [7:0] exp_q[$];
    int miscompares = 0;
    int checks = 0;
    logic [7:0] lo;
    logic [7:0] hi;

    // after reset every mode and count reads 0, matches ff, write-only and unmapped read 0
    localparam logic [11:0] RST_ADDR [9] = '{`ADDR_LOW_MODE, `ADDR_HIGH_MODE, `ADDR_LOW_MATCH, `ADDR_HIGH_MATCH,
        `ADDR_LOW_COUNT, `ADDR_HIGH_COUNT, `ADDR_OUT_ENABLE, `ADDR_STATUS, 12'h123};
    localparam logic [7:0] RST_VAL [9] = '{8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    // internal pulse codes and their tap exponents, in code order
    localparam logic [2:0] CODES [5] = '{cascade_timer_pkg::SEL_DIV_4, cascade_timer_pkg::SEL_DIV_1024,
        cascade_timer_pkg::SEL_DIV_256, cascade_timer_pkg::SEL_DIV_64, cascade_timer_pkg::SEL_DIV_16};
    localparam int EXPS [5] = '{`TAP_EXP_FAST, `TAP_EXP_SLOW, `TAP_EXP_8, `TAP_EXP_6, `TAP_EXP_4};

    cascaded_timer #(.DATA_W(8)) dut_u (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .addr_i(addr),
        .wdata_i(wdata),
        .write_i(write_s),
        .read_i(read_s),
        .low_event_input_i(event_s),
        .rdata_o(rdata),
        .timer_irq_flag_o(irq),
        .timer_output_pin_o(pin)
    );

    // 40 MHz clock
    initial begin
        clock_i = 1'b0;
        forever #12.5 clock_i = ~clock_i;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // read data stand only in the cycle after the strobe, so compare exactly there
    always @(posedge clock_i) begin
        if (rd_pend) begin
            chk({8'h00, rdata}, {8'h00, exp_q.pop_front()});
        end
        rd_pend <= read_s;
    end

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clock_i);
        write_s <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clock_i);
        write_s <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        @(posedge clock_i);
        read_s <= 1'b1;
        addr <= a;
        exp_q.push_back(e);
        @(posedge clock_i);
        read_s <= 1'b0;
    endtask

    // match bytes high then low, then the fixed high mode, then the low mode with start
    task automatic cfg(input logic [7:0] h, input logic [7:0] l, input logic [7:0] mode);
        wr(`ADDR_HIGH_MATCH, h);
        wr(`ADDR_LOW_MATCH, l);
        wr(`ADDR_HIGH_MODE, `HIGH_MODE_CASCADE);
        wr(`ADDR_LOW_MODE, mode);
    endtask

    task automatic do_reset();
        rst_i <= 1'b1;
        repeat (4) @(posedge clock_i);
        rst_i <= 1'b0;
        @(posedge clock_i);
    endtask

    task automatic reset_check();
        for (int i = 0; i < 9; i++) begin
            rd(RST_ADDR[i], RST_VAL[i]);
        end
        chk({14'h0, irq, pin}, 16'h0000);
    endtask

    // event pulses held 4 cycles high and 4 low, wider than the input synchroniser needs
    task automatic pulse(input int k);
        repeat (k) begin
            @(posedge clock_i);
            event_s <= 1'b1;
            repeat (4) @(posedge clock_i);
            event_s <= 1'b0;
            repeat (3) @(posedge clock_i);
        end
    endtask

    // counts edges until the flag is seen low then high; bounded so a dead timer cannot hang
    task automatic wait_rise(output int n);
        n = 0;
        while (irq !== 1'b0 && n < 6000) begin
            @(posedge clock_i);
            n++;
        end
        while (irq !== 1'b1 && n < 6000) begin
            @(posedge clock_i);
            n++;
        end
    endtask

    // first rise only syncs, since the prescaler phase at start is unknown
    task automatic period_check(input int per);
        int n;
        logic p0;
        wait_rise(n);
        p0 = pin;
        wr(`ADDR_STATUS, 8'h01);
        wait_rise(n);
        chk(16'(n + 2), 16'(per));
        chk({15'h0, pin}, {15'h0, ~p0});
    endtask

    task automatic summarize();
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // watchdog sized well above the longest expected run
    initial begin
        repeat (80000) @(posedge clock_i);
        miscompares++;
        summarize();
    end

    // main sequence
    initial begin
        rst_i = 1'b1;
        write_s = 1'b0;
        read_s = 1'b0;
        addr = '0;
        wdata = '0;
        event_s = 1'b0;
        void'($urandom(94));
        do_reset();
        reset_check();
        $display("test reset done");
        // events: match 0x0105, low half alone matches early without a flag
        cfg(8'h01, 8'h05, 8'h0e);
        pulse(259);
        rd(`ADDR_LOW_COUNT, 8'h03);
        rd(`ADDR_HIGH_COUNT, 8'h01);
        chk({15'h0, irq}, 16'h0000);
        pulse(3);
        chk({15'h0, irq}, 16'h0001);
        rd(`ADDR_LOW_COUNT, 8'h00);
        rd(`ADDR_HIGH_COUNT, 8'h00);
        rd(`ADDR_STATUS, 8'h03);
        wr(`ADDR_LOW_MODE, 8'h0e);
        rd(`ADDR_LOW_MODE, 8'h06);
        rd(`ADDR_STATUS, 8'h02);
        pulse(2);
        rd(`ADDR_LOW_COUNT, 8'h02);
        wr(`ADDR_LOW_MODE, 8'h02);
        pulse(3);
        rd(`ADDR_LOW_COUNT, 8'h02);
        // falling-edge select restarts and counts only the trailing edges
        wr(`ADDR_LOW_MODE, 8'h1e);
        pulse(3);
        rd(`ADDR_LOW_COUNT, 8'h03);
        $display("test events done");
        // toggle flop is 1 here; the enable gates it to the pin
        wr(`ADDR_OUT_ENABLE, 8'h08);
        repeat (2) @(posedge clock_i);
        chk({15'h0, pin}, 16'h0001);
        wr(`ADDR_OUT_ENABLE, 8'h00);
        repeat (2) @(posedge clock_i);
        chk({15'h0, pin}, 16'h0000);
        wr(`ADDR_OUT_ENABLE, 8'h08);
        $display("test output enable done");
        // every internal code with match 1: two taps per interval
        for (int i = 0; i < 5; i++) begin
            cfg(8'h00, 8'h01, {1'b0, CODES[i], 4'he});
            period_check(2 << EXPS[i]);
        end
        $display("test pulse codes done");
        // random 9-bit matches on the fastest tap, low byte never zero
        repeat (3) begin
            lo = 8'($urandom_range(255, 1));
            hi = 8'($urandom_range(1, 0));
            cfg(hi, lo, 8'h3e);
            period_check(({hi, lo} + 1) * 4);
        end
        $display("test random intervals done");
        do_reset();
        reset_check();
        $display("test second reset done");
        summarize();
    end

endmodule // cascaded_16bit_interval_timer_tb
